// File: plx_exec.sv
// Decode and execute of pointer literal add, add-and-return and call through the working register.
`timescale 1ns/100ps
// Notes on behaviour
// (RL1) Pointer add is recognised from a word whose top byte is 1110 1000, then a 2-bit selector and a 6-bit literal.
// (RL2) Selector 0, 1 or 2 adds the literal 0 to 63 to that pointer and writes the sum back to it.
// (RL3) Selector 11 turns the instruction into add-to-stack-pointer-and-return, touching only the stack pointer.
// (RL4) Add-and-return adds the literal to the stack pointer and then returns from the return stack top.
// (RL5) The return pops the hardware stack and uses the popped address as the next fetch address.
// (RL6) Add-and-return takes two cycles, the second a no-operation while the refetch happens.
// (RL7) Call via working register, opcode 0000 0000 0001 0100, first pushes PC plus 2.
// (RL8) The call then replaces the low PC byte with the working register value.
// (RL9) The call copies the high latch into the PC high byte and the upper latch into the PC upper byte.
// (RL10) The call takes two cycles, the second a no-operation while the target is fetched.
// (RL11) The call saves no shadow copy of working, status or bank select registers.
// (RL12) All three instructions exist only while the extension enable bit is set.
// (RL13) None of the three changes any arithmetic status flag.
// (RL14) Pointer addition carries across the full pointer width.
module plx_exec #(
  parameter int PC_W  = plx_pkg::PC_W,
  parameter int PTR_W = plx_pkg::PTR_W
) (
  input  wire logic                           CLK,
  input  wire logic                           ARST_N,
  input  wire logic                           INSTR_VALID,
  input  wire logic [plx_pkg::INSTR_W-1:0]    INSTR,
  input  wire logic [PC_W-1:0]                PC,
  input  wire logic                           EXTENSION_ENABLE_BIT,
  input  wire logic [7:0]                     WORKING_REGISTER_FILE_ALIAS,
  input  wire logic [7:0]                     PC_HIGH_LATCH,
  input  wire logic [7:0]                     PC_UPPER_LATCH,
  input  wire logic [PC_W-1:0]                RETURN_STACK_TOP,
  output logic                                CLAIM,
  output logic                                STALL_NOP,
  output logic                                STACK_PUSH,
  output logic [PC_W-1:0]                     STACK_PUSH_DATA,
  output logic                                STACK_POP,
  output logic                                PC_LOAD,
  output logic [PC_W-1:0]                     PC_LOAD_DATA,
  output logic [PTR_W-1:0]                    PTR0,
  output logic [PTR_W-1:0]                    PTR1,
  output logic [PTR_W-1:0]                    SOFTWARE_STACK_POINTER,
  output logic                                STATUS_WRITE
);

  plx_pkg::plx_state_t state_q;
  plx_pkg::plx_state_t state_d;
  logic [PTR_W-1:0]    ptr_q [3];
  logic                push_q;
  logic [PC_W-1:0]     push_data_q;
  logic                pop_q;
  logic                load_q;
  logic [PC_W-1:0]     load_data_q;

  function automatic plx_pkg::plx_op_t decode_op(input logic [15:0] w, input logic en);
    decode_op = plx_pkg::PLX_NONE;
    if (en) begin // RL12
      if (w[15:plx_pkg::OPHI_LSB] == plx_pkg::OP_PTR_ADD_HI) begin // RL1
        if (w[plx_pkg::SEL_LSB +: plx_pkg::SEL_W] == plx_pkg::SEL_STACK_RET) begin // RL3
          decode_op = plx_pkg::PLX_ADD_RET;
        end else begin
          decode_op = plx_pkg::PLX_PTR_ADD;
        end
      end else if (w == plx_pkg::OP_CALL_WORKING_REGISTER_FILE_ALIAS) begin // RL7
        decode_op = plx_pkg::PLX_CALL_W;
      end
    end
  endfunction

  wire                       in_exec  = (state_q == plx_pkg::PLX_EXEC);
  wire plx_pkg::plx_op_t     op       = in_exec && INSTR_VALID ? decode_op(INSTR, EXTENSION_ENABLE_BIT)
                                                                 : plx_pkg::PLX_NONE;
  wire [1:0]                 sel      = INSTR[plx_pkg::SEL_LSB +: plx_pkg::SEL_W];
  wire [PTR_W-1:0]           lit_ext  = {{(PTR_W-plx_pkg::LIT_W){1'b0}}, INSTR[plx_pkg::LIT_W-1:0]};
  wire [1:0]                 tgt      = (op == plx_pkg::PLX_ADD_RET) ? 2'h2 : sel;
  wire                       do_add   = (op == plx_pkg::PLX_PTR_ADD) || (op == plx_pkg::PLX_ADD_RET);
  wire [PTR_W-1:0]           sum      = ptr_q[tgt] + lit_ext; // RL14
  wire                       two_cyc  = (op == plx_pkg::PLX_ADD_RET) || (op == plx_pkg::PLX_CALL_W);
  wire [PC_W-1:0]            ret_addr = PC + PC_W'(plx_pkg::RET_STEP); // RL7
  // The call target drops the working value into the low byte; the old low byte is discarded.
  wire [PC_W-1:0]            call_tgt = PC_W'({PC_UPPER_LATCH, PC_HIGH_LATCH, WORKING_REGISTER_FILE_ALIAS}); // RL8 RL9

  // The second cycle of a two-cycle instruction is a bubble so the fetch unit can refill from the new PC.
  always_comb begin
    state_d = plx_pkg::PLX_EXEC;
    unique case (state_q)
      plx_pkg::PLX_EXEC:  state_d = two_cyc ? plx_pkg::PLX_FLUSH : plx_pkg::PLX_EXEC; // RL6 RL10
      plx_pkg::PLX_FLUSH: state_d = plx_pkg::PLX_EXEC;
    endcase
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_q <= plx_pkg::PLX_EXEC;
    end else begin
      state_q <= state_d;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_ptr
      always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
          ptr_q[gi] <= PTR_W'(plx_pkg::PTR_RESET);
        end else if (do_add && (tgt == 2'(gi))) begin
          ptr_q[gi] <= sum; // RL2 RL4
        end
      end
    end
  endgenerate

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      push_q      <= 1'b0;
      push_data_q <= '0;
      pop_q       <= 1'b0;
      load_q      <= 1'b0;
      load_data_q <= PC_W'(plx_pkg::PC_RESET);
    end else begin
      push_q <= (op == plx_pkg::PLX_CALL_W); // RL7
      pop_q  <= (op == plx_pkg::PLX_ADD_RET); // RL5
      load_q <= two_cyc;
      if (op == plx_pkg::PLX_CALL_W) begin
        push_data_q <= ret_addr;
        load_data_q <= call_tgt; // RL8 RL9
      end else if (op == plx_pkg::PLX_ADD_RET) begin
        load_data_q <= RETURN_STACK_TOP; // RL4 RL5
      end
    end
  end

  assign CLAIM                  = (op != plx_pkg::PLX_NONE);
  assign STALL_NOP              = (state_q == plx_pkg::PLX_FLUSH); // RL6 RL10
  assign STACK_PUSH             = push_q;
  assign STACK_PUSH_DATA        = push_data_q;
  assign STACK_POP              = pop_q;
  assign PC_LOAD                = load_q;
  assign PC_LOAD_DATA           = load_data_q;
  assign PTR0                   = ptr_q[0];
  assign PTR1                   = ptr_q[1];
  assign SOFTWARE_STACK_POINTER = ptr_q[2];
  // No flag or shadow register path exists in this block, so status is never written.
  assign STATUS_WRITE           = 1'b0; // RL11 RL13

  property p_ptr_add;
    @(posedge CLK) disable iff (!ARST_N)
      (op == plx_pkg::PLX_PTR_ADD && sel == 2'h0) |=> (PTR0 == $past(PTR0) + $past(lit_ext));
  endproperty
  a_ptr_add: assert property (p_ptr_add) else $error("pointer add result wrong"); // RL2

  property p_ret_add;
    @(posedge CLK) disable iff (!ARST_N)
      (op == plx_pkg::PLX_ADD_RET) |=> (SOFTWARE_STACK_POINTER == $past(SOFTWARE_STACK_POINTER) + $past(lit_ext));
  endproperty
  a_ret_add: assert property (p_ret_add) else $error("stack pointer add wrong"); // RL4

  property p_ret_untouched;
    @(posedge CLK) disable iff (!ARST_N)
      (op == plx_pkg::PLX_ADD_RET) |=> $stable(PTR0) && $stable(PTR1);
  endproperty
  a_ret_untouched: assert property (p_ret_untouched) else $error("add-return touched other pointer"); // RL3

  sequence s_ret_issue;
    op == plx_pkg::PLX_ADD_RET;
  endsequence
  sequence s_ret_done;
    STACK_POP && PC_LOAD && STALL_NOP;
  endsequence
  property p_ret_seq;
    @(posedge CLK) disable iff (!ARST_N)
      s_ret_issue |=> s_ret_done ##1 !STALL_NOP;
  endproperty
  a_ret_seq: assert property (p_ret_seq) else $error("add-return sequence wrong"); // RL5 RL6

  property p_call_push;
    @(posedge CLK) disable iff (!ARST_N)
      (op == plx_pkg::PLX_CALL_W) |=> STACK_PUSH && (STACK_PUSH_DATA == $past(PC) + 21'h000002);
  endproperty
  a_call_push: assert property (p_call_push) else $error("call push wrong"); // RL7

  property p_call_target;
    @(posedge CLK) disable iff (!ARST_N)
      (op == plx_pkg::PLX_CALL_W) |=> PC_LOAD && STALL_NOP
        && (PC_LOAD_DATA[7:0] == $past(WORKING_REGISTER_FILE_ALIAS))
        && (PC_LOAD_DATA[15:8] == $past(PC_HIGH_LATCH));
  endproperty
  a_call_target: assert property (p_call_target) else $error("call target wrong"); // RL8 RL9 RL10

  property p_disabled;
    @(posedge CLK) disable iff (!ARST_N)
      !EXTENSION_ENABLE_BIT |-> !CLAIM ##1 !PC_LOAD;
  endproperty
  a_disabled: assert property (p_disabled) else $error("claimed while extension disabled"); // RL12

  property p_carry;
    @(posedge CLK) disable iff (!ARST_N)
      (op == plx_pkg::PLX_PTR_ADD && sel == 2'h1 && PTR1[7:0] == 8'hff && lit_ext != '0)
        |=> PTR1[PTR_W-1:8] != $past(PTR1[PTR_W-1:8]);
  endproperty
  a_carry: assert property (p_carry) else $error("no carry into high pointer bits"); // RL14

  property p_no_status;
    @(posedge CLK) disable iff (!ARST_N)
      CLAIM |-> !STATUS_WRITE ##1 !STATUS_WRITE;
  endproperty
  a_no_status: assert property (p_no_status) else $error("status written"); // RL11 RL13

  property p_ptr1_add;
    @(posedge CLK) disable iff (!ARST_N)
      (op == plx_pkg::PLX_PTR_ADD && sel == 2'h1) |=> (PTR1 == $past(PTR1) + $past(lit_ext));
  endproperty
  a_ptr1_add: assert property (p_ptr1_add) else $error("pointer one add result wrong"); // RL2

  property p_ptr2_add;
    @(posedge CLK) disable iff (!ARST_N)
      (op == plx_pkg::PLX_PTR_ADD && sel == 2'h2)
        |=> (SOFTWARE_STACK_POINTER == $past(SOFTWARE_STACK_POINTER) + $past(lit_ext));
  endproperty
  a_ptr2_add: assert property (p_ptr2_add) else $error("pointer two add result wrong"); // RL2 RL14

  property p_add_one_ptr;
    @(posedge CLK) disable iff (!ARST_N)
      (op == plx_pkg::PLX_PTR_ADD && sel == 2'h0) |=> $stable(PTR1) && $stable(SOFTWARE_STACK_POINTER);
  endproperty
  a_add_one_ptr: assert property (p_add_one_ptr) else $error("pointer add touched another pointer"); // RL2

  property p_add_single;
    @(posedge CLK) disable iff (!ARST_N)
      (op == plx_pkg::PLX_PTR_ADD) |=> !STALL_NOP && !PC_LOAD && !STACK_PUSH && !STACK_POP;
  endproperty
  a_add_single: assert property (p_add_single) else $error("pointer add took a second cycle"); // RL2

  property p_ret_target;
    @(posedge CLK) disable iff (!ARST_N)
      (op == plx_pkg::PLX_ADD_RET) |=> (PC_LOAD_DATA == $past(RETURN_STACK_TOP)) && !STACK_PUSH;
  endproperty
  a_ret_target: assert property (p_ret_target) else $error("return address wrong"); // RL4 RL5

  property p_call_upper;
    @(posedge CLK) disable iff (!ARST_N)
      (op == plx_pkg::PLX_CALL_W) |=> (PC_LOAD_DATA[PC_W-1:16] == $past(PC_UPPER_LATCH[PC_W-17:0]));
  endproperty
  a_call_upper: assert property (p_call_upper) else $error("call upper target wrong"); // RL9

  property p_call_keeps_ptrs;
    @(posedge CLK) disable iff (!ARST_N)
      (op == plx_pkg::PLX_CALL_W)
        |=> $stable(PTR0) && $stable(PTR1) && $stable(SOFTWARE_STACK_POINTER) && !STACK_POP;
  endproperty
  a_call_keeps_ptrs: assert property (p_call_keeps_ptrs) else $error("call touched a pointer"); // RL11

  sequence s_call_issue;
    op == plx_pkg::PLX_CALL_W;
  endsequence
  sequence s_call_done;
    STACK_PUSH && PC_LOAD && STALL_NOP && !STACK_POP;
  endsequence
  property p_call_seq;
    @(posedge CLK) disable iff (!ARST_N)
      s_call_issue |=> s_call_done ##1 (!STALL_NOP && !STACK_PUSH && !PC_LOAD);
  endproperty
  a_call_seq: assert property (p_call_seq) else $error("call sequence wrong"); // RL10

  property p_flush_refused;
    @(posedge CLK) disable iff (!ARST_N)
      STALL_NOP |-> !CLAIM;
  endproperty
  a_flush_refused: assert property (p_flush_refused) else $error("word claimed in bubble cycle"); // RL6 RL10

  property p_invalid_ignored;
    @(posedge CLK) disable iff (!ARST_N)
      !INSTR_VALID |-> !CLAIM;
  endproperty
  a_invalid_ignored: assert property (p_invalid_ignored) else $error("claimed without valid word"); // RL1

  property p_claim_opcode;
    @(posedge CLK) disable iff (!ARST_N)
      CLAIM |-> (INSTR[15:plx_pkg::OPHI_LSB] == plx_pkg::OP_PTR_ADD_HI) || (INSTR == plx_pkg::OP_CALL_WORKING_REGISTER_FILE_ALIAS);
  endproperty
  a_claim_opcode: assert property (p_claim_opcode) else $error("claimed a foreign opcode"); // RL1 RL7

  property p_idle_ptrs;
    @(posedge CLK) disable iff (!ARST_N)
      !CLAIM |=> $stable(PTR0) && $stable(PTR1) && $stable(SOFTWARE_STACK_POINTER);
  endproperty
  a_idle_ptrs: assert property (p_idle_ptrs) else $error("pointer moved without a claim"); // RL2

  property p_pop_pulse;
    @(posedge CLK) disable iff (!ARST_N)
      STACK_POP |=> !STACK_POP && !PC_LOAD;
  endproperty
  a_pop_pulse: assert property (p_pop_pulse) else $error("pop longer than one cycle"); // RL5

  property p_push_pulse;
    @(posedge CLK) disable iff (!ARST_N)
      STACK_PUSH |=> !STACK_PUSH && !PC_LOAD;
  endproperty
  a_push_pulse: assert property (p_push_pulse) else $error("push longer than one cycle"); // RL7

  property p_stall_follows;
    @(posedge CLK) disable iff (!ARST_N)
      STALL_NOP |-> $past(two_cyc);
  endproperty
  a_stall_follows: assert property (p_stall_follows) else $error("bubble without two-cycle instruction"); // RL6 RL10

  property p_load_pulse;
    @(posedge CLK) disable iff (!ARST_N)
      PC_LOAD |=> !PC_LOAD;
  endproperty
  a_load_pulse: assert property (p_load_pulse) else $error("pc load longer than one cycle"); // RL10

endmodule

// File: plx_exec_tb_top.sv
// Random self-checking testbench for the extension execute block.
`timescale 1ns/100ps
module plx_exec_tb_top;
  localparam int PW = plx_pkg::PC_W;
  logic          clk, arst_n, ivalid, en, claim, stall, push, pop, load, stw;
  logic [15:0]   instr;
  logic [PW-1:0] pc, top, push_d, load_d;
  logic [7:0]    working_register_file_alias, hlat, ulat;
  logic [11:0]   p0, p1, p2;
  logic [11:0]   ep [3];
  logic          est;
  int            fails, comparisons, cyc;
  logic [15:0]   corner [12] = '{16'he87f, 16'he87f, 16'he87f, 16'he87f, 16'he843, 16'he841,
                                 16'he8ff, 16'h0014, 16'h0014, 16'he8bf, 16'he83f, 16'he9bf};

  plx_exec dut (.CLK(clk), .ARST_N(arst_n), .INSTR_VALID(ivalid), .INSTR(instr), .PC(pc),
    .EXTENSION_ENABLE_BIT(en), .WORKING_REGISTER_FILE_ALIAS(working_register_file_alias), .PC_HIGH_LATCH(hlat),
    .PC_UPPER_LATCH(ulat), .RETURN_STACK_TOP(top), .CLAIM(claim), .STALL_NOP(stall),
    .STACK_PUSH(push), .STACK_PUSH_DATA(push_d), .STACK_POP(pop), .PC_LOAD(load),
    .PC_LOAD_DATA(load_d), .PTR0(p0), .PTR1(p1), .SOFTWARE_STACK_POINTER(p2), .STATUS_WRITE(stw));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Classifies a word: 0 ignored, 1 pointer add, 2 add-and-return, 3 call.
  function automatic int kind(logic [15:0] w, logic v, logic e, logic s);
    if (!v || !e || s) return 0;
    if (w === 16'h0014) return 3;
    if (w[15:8] === 8'he8) return (w[7:6] === 2'h3) ? 2 : 1;
    return 0;
  endfunction

  task automatic chk(input logic [PW-1:0] got, input logic [PW-1:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Everything the block drives must sit at its reset value while reset is held.
  task automatic reset_chk();
    chk({push, pop, load, stall, claim, stw}, 6'h00);
    chk(push_d, '0);
    chk(load_d, plx_pkg::PC_RESET);
    chk(p0, plx_pkg::PTR_RESET);
    chk(p1, plx_pkg::PTR_RESET);
    chk(p2, plx_pkg::PTR_RESET);
  endtask

  task automatic end_of_test();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Drives the next word, then checks what the edge took from the held word.
  task automatic step(input logic v, input logic e, input logic [15:0] w);
    int            k;
    logic [PW-1:0] xpc, xtop;
    logic [7:0]    xw, xh, xu;
    logic [15:0]   xi;
    @(posedge clk);
    k = kind(instr, ivalid, en, est);
    xpc = pc;
    xtop = top;
    xw = working_register_file_alias;
    xh = hlat;
    xu = ulat;
    xi = instr;
    if (k == 1 || k == 2) ep[k == 2 ? 2 : xi[7:6]] = ep[k == 2 ? 2 : xi[7:6]] + {6'h00, xi[5:0]};
    est = (k >= 2);
    ivalid <= v;
    en <= e;
    instr <= w;
    pc <= PW'($urandom);
    top <= PW'($urandom);
    working_register_file_alias <= 8'($urandom);
    hlat <= 8'($urandom);
    ulat <= 8'($urandom);
    #1;
    chk(stall, est);
    chk(push, k == 3);
    chk(pop, k == 2);
    chk(load, k >= 2);
    if (k == 3) chk(push_d, xpc + PW'(2));
    if (k == 3) chk(load_d, {xu[4:0], xh, xw});
    if (k == 2) chk(load_d, xtop);
    chk(p0, ep[0]);
    chk(p1, ep[1]);
    chk(p2, ep[2]);
    chk(stw, 1'b0);
    chk(claim, kind(w, v, e, est) != 0);
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 10000) begin
      fails++;
      end_of_test();
    end
  end

  initial begin
    int r;
    {arst_n, ivalid, en, instr, pc, top, working_register_file_alias, hlat, ulat, est} = '0;
    ep = '{default: 12'h000};
    void'($urandom(82337));
    repeat (3) @(posedge clk);
    #1;
    reset_chk();
    @(posedge clk);
    arst_n <= 1'b1;
    foreach (corner[i]) step(1'b1, 1'b1, corner[i]);
    step(1'b1, 1'b0, 16'he83f);
    repeat (3000) begin
      r = $urandom_range(0, 4);
      step($urandom_range(0, 5) != 0, $urandom_range(0, 7) != 0,
           r == 2 ? 16'h0014 : (r == 3 ? 16'($urandom) : {8'he8, 8'($urandom)}));
    end
    @(posedge clk);
    arst_n <= 1'b0;
    ivalid <= 1'b0;
    #1;
    reset_chk();
    ep = '{default: 12'h000};
    est = 1'b0;
    @(posedge clk);
    arst_n <= 1'b1;
    step(1'b1, 1'b1, 16'he8c5);
    step(1'b1, 1'b1, 16'he845);
    step(1'b0, 1'b1, 16'h0000);
    step(1'b0, 1'b1, 16'h0000);
    end_of_test();
  end
endmodule

// File: plx_pkg.sv
// Package holding encodings, widths and reset values for the extension execute block.
package plx_pkg;
  localparam int          INSTR_W        = 16;
  localparam int          PC_W           = 21;
  localparam int          PTR_W          = 12;
  localparam int          LIT_W          = 6;
  localparam int          SEL_W          = 2;
  localparam logic [7:0]  OP_PTR_ADD_HI  = 8'he8;
  localparam logic [15:0] OP_CALL_WORKING_REGISTER_FILE_ALIAS   = 16'h0014;
  localparam int          SEL_LSB        = 6;
  localparam int          OPHI_LSB       = 8;
  localparam logic [1:0]  SEL_STACK_RET  = 2'h3;
  localparam logic [2:0]  RET_STEP       = 3'h2;
  localparam logic [11:0] PTR_RESET      = 12'h000;
  localparam logic [20:0] PC_RESET       = 21'h000000;
  typedef enum logic [1:0] {
    PLX_NONE,
    PLX_PTR_ADD,
    PLX_ADD_RET,
    PLX_CALL_W
  } plx_op_t;
  typedef enum {
    PLX_EXEC,
    PLX_FLUSH
  } plx_state_t;
endpackage
